//--- common/rss_pkg.sv
// Constants, register map and state types of the reset source sequencer.
package rss_pkg;

  // Clock and timing.
  localparam int CLK_NS      = 25;
  localparam int PIN_MIN_NS  = 1500;
  localparam int PIN_MIN_CYC = (PIN_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_W      = 7;

  // Stretch delay choices, selected by the clock selection configuration bits.
  localparam int STRETCH_NS_0  = 100;
  localparam int STRETCH_NS_1  = 4100;
  localparam int STRETCH_NS_2  = 65000;
  localparam int STRETCH_NS_3  = 100000;
  localparam int STRETCH_CYC_0 = (STRETCH_NS_0 + CLK_NS - 1) / CLK_NS;
  localparam int STRETCH_CYC_1 = (STRETCH_NS_1 + CLK_NS - 1) / CLK_NS;
  localparam int STRETCH_CYC_2 = (STRETCH_NS_2 + CLK_NS - 1) / CLK_NS;
  localparam int STRETCH_CYC_3 = (STRETCH_NS_3 + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W         = 12;
  localparam int SEL_W         = 2;
  localparam logic [3:0][CNT_W-1:0] STRETCH_TABLE = {12'(STRETCH_CYC_3), 12'(STRETCH_CYC_2),
                                                     12'(STRETCH_CYC_1), 12'(STRETCH_CYC_0)};

  // Register map, byte addresses.
  localparam int             ADDR_W      = 8;
  localparam logic [7:0]     ADDR_CAUSE  = 8'h00;
  localparam logic [7:0]     ADDR_STATUS = 8'h04;
  localparam logic [7:0]     ADDR_DELAY  = 8'h08;

  // Reset cause flag positions.
  localparam int             FLAG_POR    = 0;
  localparam int             FLAG_EXT    = 1;
  localparam int             FLAG_BOR    = 2;
  localparam int             FLAG_WDT    = 3;
  localparam int             FLAG_SCAN   = 4;
  localparam int             NUM_SRC     = 5;
  localparam logic [4:0]     CAUSE_RST   = 5'h00;

  // Status register field positions.
  localparam int             STAT_SRC_LSB = 0;
  localparam int             STAT_COUNT   = 5;
  localparam int             STAT_CORE    = 6;
  localparam int             STAT_PORT    = 7;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b001,
    ST_COUNT = 3'b010,
    ST_RUN   = 3'b100
  } rss_state_t;

  typedef struct packed {
    rss_state_t          state;
    logic [CNT_W-1:0]    cnt;
    logic [SEL_W-1:0]    sel;
    logic [NUM_SRC-1:0]  flags;
    logic                wdt_seen;
    logic                wdt_pulse;
    logic                core_reset;
    logic                fetch_start;
    logic [15:0]         fetch_addr;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } rss_top_state_t;

  typedef struct packed {
    logic [FILT_W-1:0]   cnt;
    logic                qual;
  } rss_filt_state_t;

  typedef struct packed {
    logic                stage1;
    logic                stage2;
  } rss_hold_state_t;

endpackage : rss_pkg

//--- common/rss_src_if.sv
// Interface joining the sequencer core to its pin filter and port reset holder.
`timescale 1ns/1ps
interface rss_src_if;
  logic pin_n;
  logic pin_qualified;
  logic async_set;
  logic port_reset;

  modport top  (output pin_n, output async_set, input pin_qualified, input port_reset);
  modport filt (input pin_n, output pin_qualified);
  modport hold (input async_set, output port_reset);
endinterface : rss_src_if

//--- logic/rss_pin_filter.sv
// Minimum pulse length qualifier for the external reset pin.
`timescale 1ns/1ps
module rss_pin_filter
  import rss_pkg::*;
#(
  parameter int MIN_CYC = PIN_MIN_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pin side.
  rss_src_if.filt  src
);

  if (MIN_CYC < 1 || MIN_CYC > 127) begin : g_check
    $error("MIN_CYC out of range");
  end

  rss_filt_state_t s;
  rss_filt_state_t next_s;

  // Short glitches never reach the qualified level.
  always_comb begin
    next_s = s;
    if (src.pin_n) begin
      next_s.cnt  = '0;
      next_s.qual = 1'b0;
    end else begin
      if (s.cnt != FILT_W'(MIN_CYC)) begin
        next_s.cnt = s.cnt + 7'h01;
      end
      next_s.qual = (next_s.cnt == FILT_W'(MIN_CYC));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign src.pin_qualified = s.qual;

endmodule : rss_pin_filter

//--- logic/rss_port_hold.sv
// Port reset holder: asserts without a clock, releases through two flops.
`timescale 1ns/1ps
module rss_port_hold
  import rss_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // Source side.
  rss_src_if.hold  src
);

  rss_hold_state_t s;
  rss_hold_state_t next_s;

  always_comb begin
    next_s        = s;
    next_s.stage1 = 1'b0;
    next_s.stage2 = s.stage1;
  end

  // Assertion needs no clock; the release is timed so ports leave reset cleanly.
  always_ff @(posedge pclk or posedge src.async_set) begin
    if (src.async_set) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign src.port_reset = s.stage2;

endmodule : rss_port_hold

//--- logic/rss_top.sv
// Reset source sequencer: combines reset sources, stretches and releases reset.
// Functional notes
// - While internal reset is active, I/O registers are told to load their initial values.
// - On release the core starts fetching at the reset vector.
// - Port pins return to initial state as soon as any source is active.
// - Port reset asserts asynchronously, needing no running clock.
// - After all sources go inactive a delay counter stretches the internal reset.
// - Clock selection configuration bits choose the stretch length.
// - Internal reset combines exactly five sources.
// - Power-on source is active while supply is below its threshold.
// - Pin reset counts only when the pin stays low past the minimum length; port reset here follows the raw pin level, so a glitch still asserts it.
// - Watchdog source fires only if enabled and its period expires.
// - Brown-out source fires only if enabled and supply below its threshold.
// - Scan reset holds the device in reset while the scan bit is one.
// - Watchdog expiry gives a one-cycle pulse; stretch starts after it.
// - Cause register bits 4..0: scan, watchdog, brown-out, pin, power-on.
// - Power-on clears the other flags; zero writes clear any flag.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module rss_top
  import rss_pkg::*;
#(
  parameter logic [15:0] RESET_VECTOR   = 16'h0000,
  parameter int          PIN_MIN_CYCLES = PIN_MIN_CYC
) (
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Reset sources.
  input  wire logic               supply_below_por,
  input  wire logic               pin_reset_n,
  input  wire logic               watchdog_enable,
  input  wire logic               watchdog_expired,
  input  wire logic               brownout_enable,
  input  wire logic               supply_below_bot,
  input  wire logic               scan_reset_bit,
  // Non-volatile configuration.
  input  wire logic [SEL_W-1:0]   clock_select_config,
  // Reset outputs to the rest of the chip.
  output logic                    port_reset,
  output logic                    io_init,
  output logic                    core_reset,
  output logic                    fetch_start,
  output logic      [15:0]        fetch_addr
);

  if (PIN_MIN_CYCLES < 1 || PIN_MIN_CYCLES > 127) begin : g_check
    $error("PIN_MIN_CYCLES out of range");
  end

  rss_src_if src_if ();

  rss_top_state_t     s;
  rss_top_state_t     next_s;
  logic [NUM_SRC-1:0] src;
  logic               src_any;
  logic               setup_ph;
  logic               access_ph;
  logic               wr_cause;
  logic [31:0]        status_word;
  logic [31:0]        delay_word;

  rss_pin_filter #(
    .MIN_CYC (PIN_MIN_CYCLES)
  ) u_pin_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .src     (src_if.filt)
  );

  rss_port_hold u_port_hold (
    .pclk (pclk),
    .src  (src_if.hold)
  );

  assign src_if.pin_n = pin_reset_n;

  // The raw pin level goes straight to the port holder; qualification is only
  // needed before the core is reset, ports may safely blink on a glitch.
  assign src_if.async_set = ~presetn | supply_below_por | ~pin_reset_n | s.wdt_pulse
                          | (brownout_enable & supply_below_bot) | scan_reset_bit;

  // The five sources, one bit each, in cause flag order.
  always_comb begin
    src            = '0;
    src[FLAG_POR]  = supply_below_por;
    src[FLAG_EXT]  = src_if.pin_qualified;
    src[FLAG_BOR]  = brownout_enable & supply_below_bot;
    src[FLAG_WDT]  = s.wdt_pulse;
    src[FLAG_SCAN] = scan_reset_bit;
  end

  assign src_any = |src;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable & s.pready;
  assign wr_cause  = access_ph & pwrite & (paddr == ADDR_CAUSE);

  always_comb begin
    status_word                              = '0;
    status_word[STAT_SRC_LSB +: NUM_SRC]     = src;
    status_word[STAT_COUNT]                  = (s.state == ST_COUNT);
    status_word[STAT_CORE]                   = s.core_reset;
    status_word[STAT_PORT]                   = src_if.port_reset;
  end

  always_comb begin
    delay_word                    = '0;
    delay_word[CNT_W-1:0]         = s.cnt;
    delay_word[16 +: SEL_W]       = s.sel;
  end

  always_comb begin
    next_s             = s;
    next_s.fetch_start = 1'b0;

    // An expiry held for many cycles still yields exactly one pulse.
    next_s.wdt_seen  = watchdog_enable & watchdog_expired;
    next_s.wdt_pulse = watchdog_enable & watchdog_expired & ~s.wdt_seen;

    case (s.state)
      ST_HOLD: begin
        if (!src_any) begin
          next_s.state = ST_COUNT;
          next_s.sel   = clock_select_config;
          next_s.cnt   = STRETCH_TABLE[clock_select_config];
        end
      end
      ST_COUNT: begin
        if (src_any) begin
          next_s.state = ST_HOLD;
          next_s.cnt   = '0;
        end else if (s.cnt <= 12'h001) begin
          next_s.state       = ST_RUN;
          next_s.cnt         = '0;
          next_s.fetch_start = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 12'h001;
        end
      end
      ST_RUN: begin
        if (src_any) begin
          next_s.state = ST_HOLD;
        end
      end
      default: begin
        next_s.state = ST_HOLD;
        next_s.cnt   = '0;
      end
    endcase

    next_s.core_reset = (next_s.state != ST_RUN);
    if (next_s.core_reset || next_s.fetch_start) begin
      next_s.fetch_addr = RESET_VECTOR;
    end

    // Set wins over any clear in the same cycle.
    for (int i = 0; i < NUM_SRC; i++) begin
      if (wr_cause && !pwdata[i]) begin
        next_s.flags[i] = 1'b0;
      end
      if (i != FLAG_POR && src[FLAG_POR]) begin
        next_s.flags[i] = 1'b0;
      end
      if (src[i]) begin
        next_s.flags[i] = 1'b1;
      end
    end

    // APB: answer in the first access cycle, data prepared during setup.
    next_s.pready  = setup_ph;
    next_s.pslverr = 1'b0;
    if (setup_ph) begin
      case (paddr)
        ADDR_CAUSE:  next_s.prdata = {27'h0000000, s.flags};
        ADDR_STATUS: next_s.prdata = status_word;
        ADDR_DELAY:  next_s.prdata = delay_word;
        default: begin
          next_s.prdata  = '0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
  end

  // The core sees reset rise one edge after a source and fall only on an edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s            <= '0;
      s.state      <= ST_HOLD;
      s.core_reset <= 1'b1;
      s.flags      <= CAUSE_RST;
      s.fetch_addr <= 16'h0000;
    end else begin
      s <= next_s;
    end
  end

  assign prdata      = s.prdata;
  assign pready      = s.pready;
  assign pslverr     = s.pslverr;
  assign port_reset  = src_if.port_reset;
  assign io_init     = s.core_reset;
  assign core_reset  = s.core_reset;
  assign fetch_start = s.fetch_start;
  assign fetch_addr  = s.fetch_addr;

endmodule : rss_top

//--- test/rss_src_model.sv
// Behavioural model of the reset sources outside the sequencer.
`timescale 1ns/1ps
module rss_src_model (
  // Clock.
  input wire logic pclk,
  // Source levels.
  output logic     supply_below_por,
  output logic     pin_reset_n,
  output logic     watchdog_enable,
  output logic     watchdog_expired,
  output logic     brownout_enable,
  output logic     supply_below_bot,
  output logic     scan_reset_bit
);
  initial begin
    {supply_below_por, pin_reset_n} = 2'h3;
    {watchdog_enable, watchdog_expired, brownout_enable, supply_below_bot, scan_reset_bit} = 5'h00;
  end
  // The pin has a pull-up, so a released pin reads high.
  task fire(input int i, input logic en, input int n);
    @(posedge pclk);
    watchdog_enable <= en;
    brownout_enable <= en;
    case (i)
      0: pin_reset_n <= 1'b0;
      1: supply_below_bot <= 1'b1;
      2: watchdog_expired <= 1'b1;
      default: scan_reset_bit <= en;
    endcase
    repeat (n) @(posedge pclk);
    {pin_reset_n, supply_below_bot, watchdog_expired, scan_reset_bit} <= 4'h8;
  endtask : fire
  task set_por(input logic v);
    @(posedge pclk);
    supply_below_por <= v;
  endtask : set_por
endmodule : rss_src_model

//--- test/rss_top_sva.sv
// Concurrent checks on the reset source sequencer ports.
`timescale 1ns/1ps
module rss_top_sva
#(
  parameter logic [15:0] RESET_VECTOR = 16'h0000
) (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // Sources.
  input wire logic        supply_below_por,
  input wire logic        pin_reset_n,
  input wire logic        watchdog_enable,
  input wire logic        watchdog_expired,
  input wire logic        brownout_enable,
  input wire logic        supply_below_bot,
  input wire logic        scan_reset_bit,
  // Outputs.
  input wire logic        port_reset,
  input wire logic        io_init,
  input wire logic        core_reset,
  input wire logic        fetch_start,
  input wire logic [15:0] fetch_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_io;
    supply_below_por |=> io_init;
  endproperty
  a_io: assert property (p_io) else $error("io_init mismatch");
  property p_fetch;
    $fell(core_reset) |-> fetch_start && fetch_addr == RESET_VECTOR;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch at release");
  property p_port;
    supply_below_por || !pin_reset_n || scan_reset_bit |-> port_reset;
  endproperty
  a_port: assert property (p_port) else $error("port reset late");
  property p_stretch;
    $fell(core_reset) |-> $past(supply_below_por) == 0 && $past(scan_reset_bit) == 0;
  endproperty
  a_stretch: assert property (p_stretch) else $error("release with source");
  property p_por;
    supply_below_por |=> core_reset;
  endproperty
  a_por: assert property (p_por) else $error("power-on ignored");
  property p_wdt;
    $rose(watchdog_expired) && watchdog_enable |-> ##[1:3] core_reset;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog ignored");
  property p_bot;
    brownout_enable && supply_below_bot |=> core_reset;
  endproperty
  a_bot: assert property (p_bot) else $error("brown-out ignored");
  property p_scan;
    scan_reset_bit |=> core_reset;
  endproperty
  a_scan: assert property (p_scan) else $error("scan reset ignored");
  property p_apb;
    psel && !penable |=> pready;
  endproperty
  a_apb: assert property (p_apb) else $error("no ready");
  c_fetch: cover property (fetch_start);
  c_short: cover property (port_reset && !core_reset);
  c_wdt: cover property ($rose(watchdog_expired) && watchdog_enable);
endmodule : rss_top_sva

bind rss_top rss_top_sva #(.RESET_VECTOR(RESET_VECTOR)) rss_top_sva_i (.pclk, .presetn, .psel, .penable,
  .pready, .supply_below_por, .pin_reset_n, .watchdog_enable, .watchdog_expired, .brownout_enable,
  .supply_below_bot, .scan_reset_bit, .port_reset, .io_init, .core_reset, .fetch_start, .fetch_addr);

//--- test/tb_top.sv
// Self-checking testbench for the reset source sequencer.
`timescale 1ns/1ps
module tb_top
  import rss_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, wd;
  logic        supply_below_por, pin_reset_n, watchdog_enable, watchdog_expired;
  logic        brownout_enable, supply_below_bot, scan_reset_bit;
  logic [1:0]  clock_select_config;
  logic        port_reset, io_init, core_reset, fetch_start;
  logic [15:0] fetch_addr;
  int          failures, compares, k, mf;
  int          tbl[4] = '{STRETCH_CYC_0, STRETCH_CYC_1, STRETCH_CYC_2, STRETCH_CYC_3};

  rss_top #(.PIN_MIN_CYCLES(4)) rss_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .supply_below_por, .pin_reset_n, .watchdog_enable, .watchdog_expired,
    .brownout_enable, .supply_below_bot, .scan_reset_bit, .clock_select_config, .port_reset, .io_init,
    .core_reset, .fetch_start, .fetch_addr);
  rss_src_model rss_src_model_i (.pclk, .supply_below_por, .pin_reset_n, .watchdog_enable,
    .watchdog_expired, .brownout_enable, .supply_below_bot, .scan_reset_bit);

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Holds the request until pready is sampled high at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_release();
    k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (fetch_start !== 1'b1 && k < 5000);
    chk("release", fetch_start, 1'b1);
  endtask : wait_release

  task results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  initial begin
    #(25 * 60000);
    failures++;
    results();
  end

  initial begin
    {failures, compares, mf} = '0;
    {psel, penable, pwrite, paddr, pwdata, clock_select_config} = '0;
    presetn = 1'b0;
    void'($urandom(56603));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rss_src_model_i.set_por(1'b0);
    wait_release();
    chk("first_stretch", k - 1, tbl[0]);
    chk("io_init", io_init, 1'b0);
    chk("fetch_addr", fetch_addr, 16'h0000);
    mf = 1;
    // Each selection also aborts one count after its first cycle to prove the restart.
    for (int s = 0; s < 4; s++) begin
      @(posedge pclk);
      clock_select_config <= 2'(s);
      rss_src_model_i.fire(3, 1'b1, 3);
      rss_src_model_i.fire(3, 1'b1, 2);
      wait_release();
      chk("stretch", k - 1, tbl[s]);
      mf = mf | 16;
    end
    wd = $urandom;
    apb(1'b1, ADDR_CAUSE, wd);
    mf = mf & int'(wd[4:0]);
    apb(1'b0, ADDR_CAUSE, 32'h0);
    chk("cause_masked", rd, mf);
    apb(1'b1, ADDR_CAUSE, 32'h0);
    mf = 0;
    for (int i = 0; i < 4; i++) begin
      for (int en = 0; en < 2; en++) begin
        rss_src_model_i.fire(i, en[0], en ? 6 : 2);
        if (en) begin
          wait_release();
          mf = mf | (2 << i);
        end else begin
          repeat (8) @(posedge pclk);
          #1;
          chk("no_reset", core_reset, 1'b0);
          chk("port_idle", port_reset, 1'b0);
        end
        apb(1'b0, ADDR_CAUSE, 32'h0);
        chk("cause", rd, mf);
      end
    end
    rss_src_model_i.set_por(1'b1);
    repeat (3) @(posedge pclk);
    rss_src_model_i.set_por(1'b0);
    wait_release();
    apb(1'b0, ADDR_CAUSE, 32'h0);
    chk("cause_after_por", rd, 1);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_data", rd, 0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_idle", rd, 0);
    results();
  end
endmodule : tb_top
